// ---- src/watchdog_sleep_wakeup.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"
// Operation
// - Watchdog counts ticks of separate RC oscillator
// - Time-out while running resets device
// - Time-out while asleep wakes, no reset
// - Any time-out clears time-out flag
// - Config enable low disables watchdog while it stays low
// - One scaler shared, assigned by option bits
// - Clear or sleep resets watchdog and postscaler
// - Clear zeroes scaler when on watchdog, keeps its assignment
// - Sleep clears watchdog and power-down flag, sets time-out flag, stops oscillator
// - Ports hold their state during sleep
// - Master clear resets; others wake
// - Power-down flag set at power-up
// - Only clockless sources can wake
// - Sleep prefetches next instruction
// - Enabled source wakes regardless of global enable
// - Vector after wake only with global enable
// - Pending interrupt makes sleep a no-op
// - Late interrupt: full sleep, then wake
// - Interrupt response clears enable, vectors
module watchdog_sleep_wakeup
  import watchdog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdt_osc_pin,
  input wire logic watchdog_config_enable,
  input wire logic master_clear_pin_n,
  input wire logic timer_src_tick,
  input wire watchdog_pkg::core_cmd_t core_cmd,
  input wire watchdog_pkg::irq_req_t irq_req,
  input wire logic global_irq_enable,
  output logic device_reset,
  output logic wake_pulse,
  output logic prefetch_next,
  output logic vector_load,
  output logic global_irq_clear,
  output logic main_osc_enable,
  output logic io_hold,
  output logic timer_tick,
  output logic timeout_flag_n,
  output logic powerdown_flag_n
);
  import watchdog_pkg::*;

  // Two-stage synchronisers for pins; stage one feeds only stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic osc_prev; // Previous synchronised oscillator level for edge detect
  // Registers
  logic [7:0] option_config; // Scaler assignment and ratio
  logic [7:0] scaler; // Shared scaler count
  logic [`WDT_BASE_W-1:0] base; // Watchdog base counter
  logic master_clear_pin_prev; // Master clear level last cycle
  power_state_t state;
  // Next values
  logic [7:0] next_option_config;
  logic [7:0] next_scaler;
  logic [`WDT_BASE_W-1:0] next_base;
  power_state_t next_state;
  logic next_osc_prev, next_master_clear_pin_prev;
  logic next_device_reset, next_wake_pulse, next_prefetch_next;
  logic next_vector_load, next_timeout_flag_n, next_powerdown_flag_n;
  logic next_timer_tick;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  // Combinational helpers
  logic osc_edge, wdt_en, wdt_psa, base_wrap, timeout;
  logic pending_any, pending_wake, clr_wdt, sleep_go, master_clear_pin_fall;
  logic acc, hit_opt, hit_st;
  logic xfer_done; // Access phase completes at this edge
  logic [7:0] term;

  // Register index decode, shared by read and write paths
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] idx);
    reg_hit = (addr[1:0] == 2'b00) && (addr[11:`IDX_SHIFT] == idx[9:0]);
  endfunction

  // Scaler terminal count: watchdog 1:2^ps, timer 1:2^(ps+1)
  function automatic logic [7:0] ratio_term(input logic [2:0] ps, input logic scaler_assign_select);
    logic [7:0] t;
    t = (8'h01 << ps) - 8'h01;
    ratio_term = scaler_assign_select ? t : {t[6:0], 1'b1};
  endfunction

  // Pin synchronisers, kept apart from any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Master-clear stage rests high so reset release shows no false fall
      sync1 <= `SYNC_RST;
      sync2 <= `SYNC_RST;
    end else begin
      sync1 <= {wdt_osc_pin, watchdog_config_enable, master_clear_pin_n, 1'b0};
      sync2 <= sync1;
    end
  end

  // Event decode
  always_comb begin
    osc_edge = sync2[3] && !osc_prev;
    wdt_en = sync2[2];
    wdt_psa = option_config[`OPT_PSA_BIT];
    base_wrap = osc_edge && (base == `WDT_BASE_MAX);
    term = ratio_term(option_config[`OPT_PS_MSB:`OPT_PS_LSB], wdt_psa);
    // Time-out when the base wraps and the postscaler (if any) is at its end
    timeout = wdt_en && base_wrap && (!wdt_psa || scaler == term);
    pending_any = |(irq_req.flags & irq_req.enables);
    // Only clockless sources can wake the core while asleep
    pending_wake = |(irq_req.flags & irq_req.enables & `WAKE_CAPABLE_MASK);
    clr_wdt = core_cmd.clear_watchdog_instr && state == RUN;
    // A sleep with an enabled flag already pending degenerates to a no-op
    sleep_go = core_cmd.sleep_instr && state == RUN && !pending_any;
    master_clear_pin_fall = master_clear_pin_prev && !sync2[1];
    acc = psel && penable && !pready;
    // The master samples ready high here; writes land at this edge and no other
    xfer_done = psel && penable && pready;
    hit_opt = reg_hit(paddr, `OPTION_CONFIG_IDX);
    hit_st = reg_hit(paddr, `SLEEP_STATUS_IDX);
  end

  // Watchdog and scaler next values
  always_comb begin
    next_osc_prev = sync2[3];
    next_base = base;
    next_scaler = scaler;
    next_timer_tick = 1'b0;
    if (osc_edge) begin
      next_base = base + `WDT_BASE_W'(1);
    end
    if (wdt_psa) begin
      // Assigned to the watchdog: counts base wraps
      if (base_wrap) begin
        next_scaler = (scaler == term) ? `SCALER_RST : scaler + 8'h01;
      end
    end else if (timer_src_tick) begin
      // Assigned to the timer: prescales its source
      next_timer_tick = (scaler == term);
      next_scaler = (scaler == term) ? `SCALER_RST : scaler + 8'h01;
    end
    // Clear and sleep both restart the watchdog
    if (clr_wdt || sleep_go || timeout) begin
      next_base = `BASE_RST;
      if (wdt_psa) begin
        next_scaler = `SCALER_RST;
      end
    end
    // Watchdog disabled by configuration holds the base counter at zero
    if (!wdt_en) begin
      next_base = `BASE_RST;
    end
  end

  // Power state and flags next values
  always_comb begin
    next_state = state;
    next_master_clear_pin_prev = sync2[1];
    next_device_reset = 1'b0;
    next_wake_pulse = 1'b0;
    next_prefetch_next = 1'b0;
    next_vector_load = 1'b0;
    next_timeout_flag_n = timeout_flag_n;
    next_powerdown_flag_n = powerdown_flag_n;
    case (state)
      RUN: begin
        if (sleep_go) begin
          next_state = DOZE;
          next_powerdown_flag_n = 1'b0;
          next_timeout_flag_n = 1'b1;
          next_prefetch_next = 1'b1;
        end else if (core_cmd.sleep_instr) begin
          next_prefetch_next = 1'b1;
        end
        if (timeout) begin
          next_device_reset = 1'b1;
          next_timeout_flag_n = 1'b0;
        end
        // Interrupt taken while running
        if (pending_any && global_irq_enable && !sleep_go) begin
          next_vector_load = 1'b1;
        end
      end
      DOZE: begin
        if (timeout) begin
          next_state = RUN;
          next_wake_pulse = 1'b1;
          next_timeout_flag_n = 1'b0;
        end else if (pending_wake) begin
          next_state = RUN;
          next_wake_pulse = 1'b1;
          next_vector_load = global_irq_enable;
        end
      end
      default: begin
        next_state = RUN;
      end
    endcase
    // Master clear always ends in a full reset, asleep or not
    if (master_clear_pin_fall) begin
      next_state = RUN;
      next_device_reset = 1'b1;
      next_wake_pulse = 1'b0;
      next_vector_load = 1'b0;
    end
  end

  // Bus slave next values; answers on the second access cycle
  always_comb begin
    next_option_config = option_config;
    next_pready = acc;
    next_pslverr = acc && !(hit_opt || hit_st);
    next_prdata = 32'h0000_0000;
    if (xfer_done && pwrite && hit_opt) begin
      // Clear of the watchdog by software leaves the assignment alone
      next_option_config = pwdata[7:0];
    end
    if (acc && !pwrite && hit_opt) begin
      next_prdata = {24'h00_0000, option_config};
    end
    if (acc && !pwrite && hit_st) begin
      next_prdata[`ST_TO_BIT] = timeout_flag_n;
      next_prdata[`ST_PD_BIT] = powerdown_flag_n;
      next_prdata[`ST_ASLEEP_BIT] = (state == DOZE);
    end
  end

  // State registers; flags come up set at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev <= 1'b0;
      master_clear_pin_prev <= 1'b1;
      base <= `BASE_RST;
      scaler <= `SCALER_RST;
      option_config <= `OPTION_CONFIG_RST;
      state <= RUN;
      device_reset <= 1'b0;
      wake_pulse <= 1'b0;
      prefetch_next <= 1'b0;
      vector_load <= 1'b0;
      global_irq_clear <= 1'b0;
      main_osc_enable <= 1'b1;
      io_hold <= 1'b0;
      timer_tick <= 1'b0;
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      osc_prev <= next_osc_prev;
      master_clear_pin_prev <= next_master_clear_pin_prev;
      base <= next_base;
      scaler <= next_scaler;
      option_config <= next_option_config;
      state <= next_state;
      device_reset <= next_device_reset;
      wake_pulse <= next_wake_pulse;
      prefetch_next <= next_prefetch_next;
      vector_load <= next_vector_load;
      global_irq_clear <= next_vector_load;
      main_osc_enable <= (next_state == RUN);
      io_hold <= (next_state == DOZE);
      timer_tick <= next_timer_tick;
      timeout_flag_n <= next_timeout_flag_n;
      powerdown_flag_n <= next_powerdown_flag_n;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Checks; every property runs on the bus clock and rests during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Oscillator edges advance the base count one step at a time
  osc_tick_a: assert property (wdt_en && osc_edge && !clr_wdt && !sleep_go && !timeout |=>
    base == $past(base) + `WDT_BASE_W'(1))
    else $error("Watchdog base missed a tick");
  // A time-out while running must reset the device
  wdt_reset_run_a: assert property (state == RUN && timeout && !master_clear_pin_fall |=> device_reset && !timeout_flag_n)
    else $error("Run time-out gave no reset");
  // Asleep, a time-out wakes instead of resetting
  wdt_wake_doze_a: assert property (state == DOZE && timeout && !master_clear_pin_fall |=> wake_pulse && !device_reset)
    else $error("Sleep time-out did not wake");
  // Every time-out, reset or wake, drops the time-out flag
  to_on_timeout_a: assert property (timeout |=> !timeout_flag_n)
    else $error("Time-out left the flag set");
  // With the configuration enable low the base never leaves zero
  wdt_disabled_a: assert property (!wdt_en |-> !timeout ##1 base == `BASE_RST)
    else $error("Disabled watchdog counted");
  // Prescaled timer ticks only while the scaler serves the timer
  timer_tick_a: assert property (timer_tick |-> !$past(wdt_psa))
    else $error("Timer tick while scaler serves watchdog");
  // A clear restarts the base; a bus write in the same cycle may legally move the option
  clr_restart_a: assert property (clr_wdt && wdt_en && !(xfer_done && pwrite) |=>
    base == `BASE_RST && $stable(option_config))
    else $error("Clear did not restart watchdog");
  // A clear with the scaler on the watchdog zeroes it and keeps the assignment
  scaler_clear_a: assert property (clr_wdt && wdt_psa && !(xfer_done && pwrite) |=>
    scaler == `SCALER_RST && option_config[`OPT_PSA_BIT])
    else $error("Clear left the postscaler running");

  // Sleep entry: flags, oscillator and power state move together
  sleep_entry_a: assert property (sleep_go && !master_clear_pin_fall && !timeout |=> state == DOZE && !powerdown_flag_n
    && timeout_flag_n && !main_osc_enable)
    else $error("Sleep entry wrong");
  // The main oscillator stays off for the whole of sleep
  osc_off_a: assert property (state == DOZE |-> !main_osc_enable)
    else $error("Oscillator running asleep");
  // Ports hold their state for the whole of sleep
  port_hold_a: assert property (state == DOZE |-> io_hold)
    else $error("Ports not held asleep");
  // Master clear wins over everything, asleep or not
  master_clear_pin_reset_a: assert property (master_clear_pin_fall |=> device_reset && state == RUN)
    else $error("Master clear missed");
  // Leaving sleep releases the ports and restarts the oscillator
  wake_release_a: assert property (wake_pulse |-> main_osc_enable && !io_hold)
    else $error("Wake left the device held");
  // Only a real sleep clears the power-down flag
  pd_clear_only_a: assert property ($fell(powerdown_flag_n) |-> $past(sleep_go))
    else $error("Power-down flag cleared without sleep");
  // Disabled or clock-needing sources leave the core asleep
  no_wake_masked_a: assert property (state == DOZE && !timeout && !pending_wake && !master_clear_pin_fall |=>
    state == DOZE && !wake_pulse)
    else $error("Woke without an enabled source");
  // Sleep prefetches the following instruction, no-op or not
  prefetch_a: assert property (core_cmd.sleep_instr && state == RUN |=> prefetch_next)
    else $error("No prefetch on sleep");
  // An enabled source wakes; the vector follows the global enable
  irq_wake_a: assert property (state == DOZE && pending_wake && !timeout && !master_clear_pin_fall |=> wake_pulse
    && vector_load == $past(global_irq_enable))
    else $error("Interrupt wake wrong");
  // The vector is only taken with the global enable set
  vector_gie_a: assert property (vector_load |-> $past(global_irq_enable))
    else $error("Vector taken with global enable low");
  // A pending enabled flag turns sleep into a no-op
  sleep_nop_a: assert property (core_cmd.sleep_instr && state == RUN && pending_any |=> state == RUN
    && $stable(powerdown_flag_n))
    else $error("Sleep not a no-op");
  // A sleep that starts always completes before any wake
  sleep_full_a: assert property (sleep_go && !master_clear_pin_fall |=> base == `BASE_RST && !powerdown_flag_n)
    else $error("Sleep did not complete");
  // Taking the vector also tells the core to drop its global enable
  gie_clear_a: assert property (vector_load |-> global_irq_clear)
    else $error("Vector without global enable clear");

  // Bus answer: one ready pulse, error only for unmapped places, quiet when idle
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("Bus answer timing wrong");
  apb_error_a: assert property (xfer_done |-> pslverr == !(hit_opt || hit_st))
    else $error("Bus error flag wrong");
  apb_idle_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("Bus outputs not quiet");

  // Main scenarios, each to be seen at least once
  sleep_wdt_wake_c: cover property (state == DOZE && timeout ##1 wake_pulse);
  sleep_irq_wake_c: cover property (sleep_go ##[1:50] (state == DOZE && pending_wake));
  run_reset_c: cover property (state == RUN && timeout);
  sleep_nop_c: cover property (core_cmd.sleep_instr && pending_any && state == RUN);
  apb_error_c: cover property (xfer_done && pslverr);
endmodule // watchdog_sleep_wakeup
`default_nettype wire

// ---- include/watchdog_defs.svh ----
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH
// Printed register indexes; the byte address is four times the index
`define OPTION_CONFIG_IDX 12'h0081
`define SLEEP_STATUS_IDX 12'h0082
`define IDX_SHIFT 2
// Field positions inside option_config
`define OPT_PSA_BIT 3
`define OPT_PS_LSB 0
`define OPT_PS_MSB 2
// Field positions inside sleep_status
`define ST_TO_BIT 4
`define ST_PD_BIT 3
`define ST_ASLEEP_BIT 0
// Reset values
`define OPTION_CONFIG_RST 8'hFF
`define SCALER_RST 8'h00
`define BASE_RST 8'h00
// Synchroniser reset: the master-clear stage rests high, the others low
`define SYNC_RST 4'h2
// Watchdog base period in oscillator ticks, as a counter width
`define WDT_BASE_W 8
`define WDT_BASE_MAX 8'hFF
// Sources able to run without on-chip clocks (one bit per flag)
`define WAKE_CAPABLE_MASK 8'hFF
`endif

// ---- include/watchdog_pkg.sv ----
package watchdog_pkg;
  // Power state of the core
  typedef enum logic {
    RUN,
    DOZE
  } power_state_t;
  // Instruction strobes from the core
  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_instr;
  } core_cmd_t;
  // Interrupt flags with their individual enables
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
  } irq_req_t;
endpackage

// ---- tb/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Core side: instruction strobes and interrupt lines
module core_model (
  input wire logic pclk,
  input wire logic vector_load,
  output var watchdog_pkg::core_cmd_t core_cmd,
  output var watchdog_pkg::irq_req_t irq_req,
  output logic global_irq_enable
);
  import watchdog_pkg::*;
  initial begin
    core_cmd = '0;
    irq_req = '0;
    global_irq_enable = 1'b0;
  end
  // Taking the vector drops the global enable
  always @(posedge pclk) begin
    if (vector_load) begin
      global_irq_enable <= 1'b0;
    end
  end
  // Flags, enables and global enable change just after an edge
  task automatic set_irq(input logic [7:0] f, input logic [7:0] e, input logic g);
    @(posedge pclk);
    irq_req <= {f, e};
    global_irq_enable <= g;
  endtask
  // One-cycle strobe, never two in one time step
  task automatic strobe(input core_cmd_t c);
    @(posedge pclk);
    core_cmd <= c;
    @(posedge pclk);
    core_cmd <= '0;
  endtask
  // Clearing first restarts the watchdog even when the sleep is a no-op
  task automatic run_sleep();
    strobe(2'b10);
    strobe(2'b01);
  endtask
endmodule // core_model
`default_nettype wire

// ---- tb/watchdog_sleep_wakeup_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_defs.svh"
module watchdog_sleep_wakeup_tb;
  import watchdog_pkg::*;
  localparam logic [11:0] OPT_A = 12'(`OPTION_CONFIG_IDX << `IDX_SHIFT);
  localparam logic [11:0] ST_A = 12'(`SLEEP_STATUS_IDX << `IDX_SHIFT);
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  // Oscillator pin, config enable, master clear, timer source
  logic wdt_osc_pin = 1'b0, watchdog_config_enable = 1'b0, master_clear_pin_n = 1'b1, timer_src_tick = 1'b0;
  logic device_reset, wake_pulse, prefetch_next, vector_load, global_irq_clear, global_irq_enable;
  logic main_osc_enable, io_hold, timer_tick, timeout_flag_n, powerdown_flag_n;
  core_cmd_t core_cmd;
  irq_req_t irq_req;
  int n_mismatch = 0, checks_done = 0, n_w, n_r, n_t, n_v, n_g, n_p, osc_div = 0;
  watchdog_sleep_wakeup dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wdt_osc_pin, .watchdog_config_enable, .master_clear_pin_n, .timer_src_tick, .core_cmd,
    .irq_req, .global_irq_enable, .device_reset, .wake_pulse, .prefetch_next, .vector_load,
    .global_irq_clear, .main_osc_enable, .io_hold, .timer_tick, .timeout_flag_n, .powerdown_flag_n);
  core_model core (.pclk, .vector_load, .core_cmd, .irq_req, .global_irq_enable);
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Free-running RC oscillator, one tick per ten clocks
  always @(posedge pclk) begin
    osc_div <= (osc_div == 4) ? 0 : osc_div + 1;
    if (osc_div == 4) begin
      wdt_osc_pin <= ~wdt_osc_pin;
    end
  end
  // Pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge pclk) begin
    n_w += wake_pulse;
    n_r += device_reset;
    n_t += timer_tick;
    n_v += vector_load;
    n_g += global_irq_clear;
    n_p += prefetch_next;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // APB transfer; a hung slave is cut off by the watchdog below
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for a wake or reset, then let the follow-up pulses land
  task automatic wait_ev(input int lim);
    n_w = 0;
    n_r = 0;
    n_v = 0;
    n_g = 0;
    for (int i = 0; i < lim && n_w + n_r == 0; i++) begin
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    // Tests take about 12,400 cycles; a hang ends here
    #400_000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Reset values, read-only status, unmapped place
    apb(1'b0, OPT_A, 0);
    check("option reset", rd, 32'h0000_00FF);
    apb(1'b1, ST_A, 0);
    apb(1'b0, ST_A, 0);
    check("status reset", rd, 32'h0000_0018);
    apb(1'b0, 12'h20C, 0);
    check("unmapped", err, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    // Clear with the scaler on the watchdog keeps the assignment
    core.strobe(2'b10);
    apb(1'b0, OPT_A, 0);
    check("clear keeps option", rd, 32'h0000_00FF);
    // Scaler on the timer side, three ratios
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, OPT_A, r);
      apb(1'b0, OPT_A, 0);
      check("option rw", rd, r);
      n_t = 0;
      repeat (16) begin
        @(posedge pclk);
        timer_src_tick <= 1'b1;
        @(posedge pclk);
        timer_src_tick <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      check("timer ticks", n_t, 8 >> r);
    end
    // Pending enabled flag turns sleep into a no-op
    core.set_irq(8'h01, 8'h01, 1'b0);
    n_p = 0;
    core.run_sleep();
    repeat (3) @(posedge pclk);
    check("prefetch", n_p, 1);
    check("noop pd", powerdown_flag_n, 1'b1);
    // Real sleep, then enabled flag wakes into the vector
    core.set_irq(8'h00, 8'h01, 1'b1);
    core.run_sleep();
    repeat (3) @(posedge pclk);
    check("sleep pd", {powerdown_flag_n, timeout_flag_n, main_osc_enable}, 3'b010);
    check("sleep hold", io_hold, 1'b1);
    core.set_irq(8'h01, 8'h01, 1'b1);
    wait_ev(50);
    check("irq wake", n_w, 1);
    check("vector", n_v != 0, 1'b1);
    check("gie clear", n_g != 0, 1'b1);
    // Disabled source and disabled watchdog must not wake
    core.set_irq(8'h00, 8'h01, 1'b0);
    core.run_sleep();
    core.set_irq(8'h02, 8'h01, 1'b0);
    wait_ev(3000);
    check("no wake", n_w, 0);
    core.set_irq(8'h03, 8'h01, 1'b0);
    wait_ev(50);
    check("plain wake", n_w, 1);
    check("plain no vector", n_v, 0);
    // Time-out asleep wakes without reset
    core.set_irq(8'h00, 8'h00, 1'b0);
    watchdog_config_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    core.run_sleep();
    wait_ev(3000);
    check("wdt wake", n_w, 1);
    check("wdt no reset", n_r, 0);
    apb(1'b0, ST_A, 0);
    check("status wake", rd, 32'h0000_0000);
    // Clears hold the reset off; then a running time-out resets
    repeat (3) begin
      core.strobe(2'b10);
      wait_ev(2000);
      check("cleared", n_r, 0);
    end
    wait_ev(3000);
    check("wdt reset", n_r, 1);
    check("reset flag", timeout_flag_n, 1'b0);
    // Master clear from sleep resets and keeps both flags
    core.run_sleep();
    master_clear_pin_n <= 1'b0;
    wait_ev(50);
    master_clear_pin_n <= 1'b1;
    check("master_clear_pin", n_r, 1);
    check("master_clear_pin no wake", n_w, 0);
    check("master_clear_pin flags", {timeout_flag_n, powerdown_flag_n, main_osc_enable}, 3'b101);
    complete_run();
  end
endmodule // watchdog_sleep_wakeup_tb
`default_nettype wire
